// file: verification/qfr_ctrl_asserts.sv
// checker for the serial read controller: link timing and pin rules
// assumes it is bound into qfr_ctrl and sees only its ports
`timescale 1ns/1ps
module qfr_ctrl_asserts #(
	parameter int DIV_W = 8
)(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic [1:0] select_to_clock_delay_field_in,
	input wire logic [DIV_W-1:0] clk_div_in,
	input wire logic frame_irq_en_in,
	input wire logic [3:0] qio_out,
	input wire logic [3:0] qio_oe_n_out,
	input wire logic tx_take_out,
	input wire logic sclk_out,
	input wire logic cs_n_out,
	input wire logic busy_out,
	input wire logic frame_irq_out
);
	logic [1:0] dly;
	logic [DIV_W-1:0] half;
	logic [15:0] since_take;
	logic [15:0] since_fall;
	logic [15:0] high_run;
	logic was_high;
	logic fell_once;
	wire take = start_in && !busy_out;
	wire fall_seen = was_high && !sclk_out;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	// counters measure link timing against the settings taken at start
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			dly <= 2'h0;
			half <= DIV_W'(2);
			since_take <= 16'h0000;
			since_fall <= 16'h0000;
			high_run <= 16'h0000;
			was_high <= 1'b0;
			fell_once <= 1'b0;
		end
		else
		begin
			dly <= take ? select_to_clock_delay_field_in : dly;
			half <= !take ? half : (clk_div_in < 2) ? DIV_W'(2) : clk_div_in;
			since_take <= take ? 16'h0000 : since_take + 16'h0001;
			since_fall <= fall_seen ? 16'h0001 : since_fall + 16'h0001;
			high_run <= sclk_out ? high_run + 16'h0001 : 16'h0000;
			was_high <= sclk_out;
			fell_once <= !take && (fell_once || fall_seen);
		end
	end
	AST_START_TAKEN: assert property (
		start_in && !busy_out |=> !cs_n_out && busy_out)
		else $error("start on idle controller not taken");
	AST_IDLE_LOW: assert property (
		cs_n_out |-> !sclk_out && qio_oe_n_out[0])
		else $error("serial clock or lane active while deselected");
	AST_LEAD_DELAY: assert property (
		fall_seen && !fell_once |-> since_take == (int'(dly) + 1) * 2 * half)
		else $error("select lead before first fall wrong");
	AST_TRAIL_DELAY: assert property (
		$rose(cs_n_out) |-> since_fall == 4 * int'(half))
		else $error("select release not two periods after last fall");
	AST_HIGH_TIME: assert property (
		$fell(sclk_out) |-> int'(high_run) == int'(half))
		else $error("serial clock high phase differs from divider");
	AST_UPPER_LANES: assert property (
		qio_oe_n_out[3:1] == 3'h7)
		else $error("upper lanes enabled");
	AST_SELECT_HELD: assert property (
		busy_out |-> !cs_n_out)
		else $error("select dropped during frame");
	AST_OUT_EDGE: assert property (
		!cs_n_out && $changed(qio_out[0]) |->
			$fell(sclk_out) || tx_take_out || $past(tx_take_out))
		else $error("outgoing lane moved off a falling edge");
	// the pulse shares its cycle with the first sample of the raised select
	AST_FRAME_PULSE: assert property (
		$rose(cs_n_out) |-> frame_irq_out == $past(frame_irq_en_in))
		else $error("frame pulse missing");
endmodule // qfr_ctrl_asserts
bind qfr_ctrl qfr_ctrl_asserts #(.DIV_W(DIV_W)) u_qfr_chk (
	.clk_in, .rstn_in, .start_in, .select_to_clock_delay_field_in,
	.clk_div_in, .frame_irq_en_in, .qio_out, .qio_oe_n_out, .tx_take_out,
	.sclk_out, .cs_n_out, .busy_out, .frame_irq_out
);

// file: verification/qfr_flash_model.sv
// behavioural serial flash answering reads on up to four lines
// assumes mode 0 clocking from the controller; lanes pass through the bench
`timescale 1ns/1ps
module qfr_flash_model #(
	parameter int LAUNCH_NS = 1
)(
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic [3:0] seed_in,
	output logic [3:0] d_out
);
	logic [3:0] nib;
	initial d_out = 4'h0;
	initial nib = 4'h0;
	// first nibble appears once selected, before the first fall that samples it
	always @(negedge cs_n_in)
	begin
		#LAUNCH_NS;
		nib = seed_in;
		d_out = nib;
	end
	// next nibble launched after each fall, stable to the next one
	always @(negedge sclk_in)
	begin
		#LAUNCH_NS;
		if (!cs_n_in)
		begin
			nib = nib + 4'h1;
			d_out = nib;
		end
	end
	// released lines must not keep showing the last value
	always @(posedge cs_n_in)
	begin
		#LAUNCH_NS;
		d_out = ~d_out;
	end
endmodule // qfr_flash_model

// file: verification/tb.sv
// self-checking bench: controller against a flash model and a word queue
// assumes the checker binds itself; link clock is 80 ns (divider 4), 40 ns in the last run (divider 1 clamped to 2)
`timescale 1ns/1ps
module tb;
	logic clk_in, rstn_in, start_in, write_mode_in, rd_ready_in, stop;
	logic word_irq_en_in, frame_irq_en_in, tx_take_out, sclk_out, cs_n_out;
	logic busy_out, word_irq_out, frame_irq_out, rd_valid_out;
	logic [1:0] lane_mode_in, pin_config_in, select_to_clock_delay_field_in;
	logic [6:0] word_len_m1_in;
	logic [11:0] word_cnt_m1_in;
	logic [7:0] clk_div_in;
	logic [127:0] tx_word_in, rd_data_out;
	logic [3:0] qio_out, qio_oe_n_out, fl_d, seed;
	wire [3:0] qio_in = (qio_oe_n_out & fl_d) | (~qio_oe_n_out & qio_out);
	logic [127:0] expq[$];
	int err_count = 0;
	int cmp_count = 0;
	int wic = 0;
	int fic = 0;
	int unsigned rs = 32'h00014414;
	int txlen = 1;
	logic txd = 1'b0;
	logic bq[$];
	qfr_ctrl i_dut (.clk_in, .rstn_in, .start_in, .write_mode_in,
		.lane_mode_in, .pin_config_in, .select_to_clock_delay_field_in,
		.word_len_m1_in, .word_cnt_m1_in, .clk_div_in, .word_irq_en_in,
		.frame_irq_en_in, .tx_word_in, .tx_take_out, .qio_in, .qio_out,
		.qio_oe_n_out, .sclk_out, .cs_n_out, .busy_out, .word_irq_out,
		.frame_irq_out, .rd_valid_out, .rd_ready_in, .rd_data_out);
	qfr_flash_model i_flash (.sclk_in(sclk_out), .cs_n_in(cs_n_out),
		.seed_in(seed), .d_out(fl_d));
	function automatic int unsigned rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one frame: predict words from the flash pattern, start, await release
	task automatic run(input logic wm, input logic [1:0] ln, pc, dl,
		input int len, input int nw, input logic [7:0] dv, input logic hold);
		int n;
		int f;
		int k;
		logic [3:0] nb;
		logic [127:0] acc;
		logic [3:0] s;
		logic we;
		logic fe;
		// only the six-pin setup reads on more than one lane
		n = (wm || pc != 2'h2) ? 1 :
			(ln == 2'h1) ? 2 : (ln == 2'h2) ? 4 : 1;
		// d0 carries outgoing bits in writes and full-duplex single reads
		txd = wm || (n == 1 && pc != 2'h0);
		txlen = len;
		f = (len + n - 1) / n;
		k = 0;
		s = 4'(rnd());
		we = 1'(rnd());
		fe = 1'(rnd());
		for (int w = 0; w < nw; w++)
		begin
			acc = '0;
			for (int i = 0; i < f; i++)
			begin
				nb = s + 4'(k);
				k++;
				if (n == 4)
					acc = {acc[123:0], nb};
				else if (n == 2)
					acc = {acc[125:0], nb[1:0]};
				else
					acc = {acc[126:0], (pc == 2'h0) ? nb[0] : nb[1]};
			end
			if (!wm)
				expq.push_back(acc & ({128{1'b1}} >> (128 - len)));
		end
		wic = 0;
		fic = 0;
		seed <= s;
		write_mode_in <= wm;
		lane_mode_in <= ln;
		pin_config_in <= pc;
		select_to_clock_delay_field_in <= dl;
		word_len_m1_in <= 7'(len - 1);
		word_cnt_m1_in <= 12'(nw - 1);
		clk_div_in <= dv;
		word_irq_en_in <= we;
		frame_irq_en_in <= fe;
		stop <= hold;
		start_in <= 1'b1;
		@(posedge clk_in);
		start_in <= 1'b0;
		@(posedge clk_in);
		if (hold)
		begin
			repeat (1000) @(posedge clk_in);
			check(cs_n_out, 1'b0);
			check(sclk_out, 1'b0);
			check(rd_valid_out, 1'b1);
			stop <= 1'b0;
		end
		for (int t = 0; t < 60000 && busy_out !== 1'b0; t++)
			@(posedge clk_in);
		check(busy_out, 1'b0);
		repeat (3) @(posedge clk_in);
		check(wic, we ? nw : 0);
		check(fic, fe ? 1 : 0);
	endtask
	// clock only; reset is driven from the initial block below
	always #5 clk_in = ~clk_in;
	// consumer stalls at random; every popped word must match the prediction
	always @(posedge clk_in)
	begin
		if (rd_valid_out && rd_ready_in)
			check(rd_data_out, expq.pop_front());
		if (word_irq_out)
			wic++;
		if (frame_irq_out)
			fic++;
		// bits of each word taken for the outgoing lane, first bit on top
		if (tx_take_out && txd)
			for (int i = txlen - 1; i >= 0; i--)
				bq.push_back(tx_word_in[i]);
		if (tx_take_out)
			tx_word_in <= {rnd(), rnd(), rnd(), rnd()};
		rd_ready_in <= !stop && 1'(rnd());
	end
	// far side of the outgoing lane samples at each rise, as in mode 0
	always @(posedge sclk_out)
	begin
		if (txd)
			check(qio_out[0], bq.pop_front());
	end
	initial
	begin
		repeat (32'h00015F90) @(posedge clk_in);
		err_count++;
		close_out();
	end
	initial
	begin
		clk_in = 1'b0;
		rstn_in = 1'b0;
		{start_in, write_mode_in, rd_ready_in, stop} = 4'h0;
		{word_irq_en_in, frame_irq_en_in, seed} = 6'h00;
		{lane_mode_in, pin_config_in, select_to_clock_delay_field_in} = 6'h00;
		{word_len_m1_in, word_cnt_m1_in, clk_div_in} = 27'h0000000;
		tx_word_in = 128'h0;
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		check({cs_n_out, sclk_out, rd_valid_out}, 3'h4);
		check(qio_oe_n_out, 4'hF);
		// every lane and pin setting, every lead delay, length extremes
		for (int m = 0; m < 16; m++)
			run(1'b0, m[1:0], m[3:2], m[1:0], (m == 0) ? 128 : (m == 1) ? 1 :
				1 + int'(rnd() % 128), 1 + int'(rnd() % 3), 8'h04, 1'b0);
		run(1'b1, 2'h0, 2'h1, 2'h2, 16, 3, 8'h04, 1'b0);
		run(1'b0, 2'h2, 2'h2, 2'h1, 8, 20, 8'h04, 1'b1);
		// full word count with the divider clamped to its floor
		run(1'b0, 2'h2, 2'h2, 2'h3, 1, 4096, 8'h01, 1'b0);
		for (int t = 0; t < 20000 && expq.size() > 0; t++)
			@(posedge clk_in);
		// let the last pop settle before looking at the valid flag
		repeat (2) @(posedge clk_in);
		check(expq.size(), 0);
		check(rd_valid_out, 1'b0);
		close_out();
	end
endmodule // tb

// file: verilog/qfr_ctrl.sv
// quad serial flash read sequencer: divider, select timing, shifters
// assumes control inputs on clk_in; qio pins come from outside the domain
`timescale 1ns/1ps
// Operation
// R1: always controller: drives serial clock and select, never acts as target.
// R2: reads over one, two or four data lines, chosen per frame.
// R3: received words appear as whole parallel words, no bit handling.
// R4: word length programmable from 1 to 128 bits.
// R5: 1 to 4096 words per frame, select held low for the whole frame.
// R6: 3-, 4- or 6-pin setup enables only the lines it needs.
// R7: optional pulse per finished word and per finished frame.
// R8: select-to-data delay programmable from 0 to 3 serial clocks.
// R9: serial clock idles low, phase zero: clock mode 0.
// R10: input lines sampled at serial clock falling edges.
// R11: flash launches read bits on falling edges, stable to the next one.
// R12: outgoing line changes together with serial clock falling edges.
// R13: select low delay field plus one periods before the first fall.
// R14: select released two serial periods after the final fall.
// R15: serial clock from programmable divider, running only during frames.
module qfr_ctrl #(
	parameter int MAX_WORD_BITS = 128,
	parameter int MAX_WORDS = 4096,
	parameter int DIV_W = 8,
	parameter int FIFO_DEPTH = 16
)(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic write_mode_in,
	input wire logic [1:0] lane_mode_in,
	input wire logic [1:0] pin_config_in,
	input wire logic [1:0] select_to_clock_delay_field_in,
	input wire logic [$clog2(MAX_WORD_BITS)-1:0] word_len_m1_in,
	input wire logic [$clog2(MAX_WORDS)-1:0] word_cnt_m1_in,
	input wire logic [DIV_W-1:0] clk_div_in,
	input wire logic word_irq_en_in,
	input wire logic frame_irq_en_in,
	input wire logic [MAX_WORD_BITS-1:0] tx_word_in,
	output logic tx_take_out,
	input wire logic [3:0] qio_in,
	output logic [3:0] qio_out,
	output logic [3:0] qio_oe_n_out,
	output logic sclk_out,
	output logic cs_n_out,
	output logic busy_out,
	output logic word_irq_out,
	output logic frame_irq_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [MAX_WORD_BITS-1:0] rd_data_out
);
	localparam int MW = MAX_WORD_BITS;
	localparam int LW = $clog2(MAX_WORD_BITS);
	localparam int CW = $clog2(MAX_WORDS);
	localparam int BW = LW + 1;
	localparam logic [DIV_W-1:0] MIN_HALF =
		DIV_W'(qfr_pkg::MIN_HALF_CYC);

	// shifters need room for a quad step; counters need exact powers of two
	generate
		if (MW < 4 || (MW & (MW - 1)) != 0)
		begin : g_bad_width
			$error("qfr_ctrl word width must be a power of two >= 4");
		end
		if ((MAX_WORDS & (MAX_WORDS - 1)) != 0 || MAX_WORDS < 2)
		begin : g_bad_words
			$error("qfr_ctrl word count must be a power of two >= 2");
		end
		if ((1 << DIV_W) <= qfr_pkg::MIN_HALF_CYC)
		begin : g_bad_div
			$error("qfr_ctrl divider too narrow for least half period");
		end
	endgenerate

	// lanes usable for a given request and pin setup
	function automatic logic [2:0] qfr_lanes(
		input logic wr_mode,
		input logic [1:0] mode,
		input logic [1:0] pins
	);
		logic [2:0] n;
		n = 3'h1;
		if (!wr_mode && pins == qfr_pkg::PINS_6)
		begin
			if (mode == qfr_pkg::LANE_QUAD)
				n = 3'h4;
			else if (mode == qfr_pkg::LANE_DUAL)
				n = 3'h2;
		end
		return n;
	endfunction

	qfr_pkg::qfr_state_t state;
	qfr_pkg::qfr_state_t next_state;

	// frame configuration, latched at start
	logic cfg_write;
	logic cfg_3pin;
	logic [2:0] cfg_lanes;
	logic [1:0] cfg_dly;
	logic [BW-1:0] cfg_len;
	logic [CW-1:0] cfg_cnt;
	logic [DIV_W-1:0] half_cyc;

	// timing and progress
	logic [DIV_W-1:0] hcnt;
	logic [3:0] hh;
	logic [BW-1:0] bit_cnt;
	logic [CW-1:0] word_cnt;
	logic sclk;
	logic cs_n;

	// data path
	logic [MW-1:0] tx_sh;
	logic [MW-1:0] rx_sh;
	logic [MW-1:0] hold;
	logic hold_valid;
	logic cap_d1;
	logic cap_d2;
	logic last_d1;
	logic last_d2;
	logic [3:0] qio_meta;
	logic [3:0] qio_sync;
	logic word_irq;
	logic frame_irq;
	logic tx_take;

	qfr_stream_if #(.WIDTH(MW)) push_if ();
	qfr_stream_if #(.WIDTH(MW)) pop_if ();

	// half-period divider, held in reset outside a frame
	wire is_idle = (state == qfr_pkg::qfr_st_idle);
	wire tick = !is_idle && (hcnt == half_cyc - 1'b1); // R15
	wire start_ok = is_idle && start_in;
	wire [DIV_W-1:0] start_half =
		(clk_div_in < MIN_HALF) ? MIN_HALF : clk_div_in; // R15

	// edge scheduling
	wire [3:0] lead_last = {1'b0, cfg_dly, 1'b0} + 4'(0); // R8
	wire at_boundary = (bit_cnt == '0);
	// a read word may not start while the last one still waits for room
	wire stall = !cfg_write && at_boundary &&
		(hold_valid || last_d1 || last_d2);
	wire lead_rise = tick && (state == qfr_pkg::qfr_st_lead) &&
		(hh == lead_last) && !stall; // R13
	wire run_rise = tick && (state == qfr_pkg::qfr_st_run) && !sclk &&
		!stall;
	wire rise_evt = lead_rise || run_rise;
	wire fall_evt = tick && (state == qfr_pkg::qfr_st_run) && sclk; // R9
	wire [BW-1:0] bits_next = bit_cnt + BW'(cfg_lanes);
	wire word_end = fall_evt && (bits_next >= cfg_len); // R4
	wire frame_end = word_end && (word_cnt == cfg_cnt); // R5
	wire trail_done = tick && (state == qfr_pkg::qfr_st_trail) &&
		(hh == qfr_pkg::TRAIL_HALVES - 4'h1); // R14

	// transmit word, left aligned so its first bit sits on top
	wire [BW-1:0] start_len = {1'b0, word_len_m1_in} + 1'b1;
	wire [BW-1:0] tx_len = is_idle ? start_len : cfg_len;
	wire [MW-1:0] tx_aligned = tx_word_in << (MW - int'(tx_len));

	// receive step: single lane uses d0 on three pins, d1 otherwise
	wire single_bit = cfg_3pin ? qio_sync[0] : qio_sync[1]; // R6
	wire [MW-1:0] rx_next =
		(cfg_lanes == 3'h4) ? {rx_sh[MW-5:0], qio_sync} :
		(cfg_lanes == 3'h2) ? {rx_sh[MW-3:0], qio_sync[1:0]} :
		{rx_sh[MW-2:0], single_bit}; // R2
	wire [MW-1:0] len_mask = {MW{1'b1}} >> (MW - int'(cfg_len));
	wire hold_load = cap_d2 && last_d2;

	// d0 is driven for writes and full-duplex single reads only
	wire drv0 = cfg_write || (cfg_lanes == 3'h1 && !cfg_3pin); // R6

	// frame sequencer
	always_comb
	begin
		next_state = state;
		unique case (state)
			qfr_pkg::qfr_st_idle:
				if (start_in)
					next_state = qfr_pkg::qfr_st_lead;
			qfr_pkg::qfr_st_lead:
				if (lead_rise)
					next_state = qfr_pkg::qfr_st_run;
			qfr_pkg::qfr_st_run:
				if (frame_end)
					next_state = qfr_pkg::qfr_st_trail;
			qfr_pkg::qfr_st_trail:
				if (trail_done)
					next_state = qfr_pkg::qfr_st_idle;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			state <= qfr_pkg::qfr_st_idle;
		else
			state <= next_state;
	end

	// configuration latch; inputs other than the two pulse enables may change freely during a frame
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cfg_write <= 1'b0;
			cfg_3pin <= 1'b0;
			cfg_lanes <= 3'h1;
			cfg_dly <= 2'h0;
			cfg_len <= BW'(1);
			cfg_cnt <= '0;
			half_cyc <= MIN_HALF;
		end
		else if (start_ok)
		begin
			cfg_write <= write_mode_in;
			cfg_3pin <= (pin_config_in == qfr_pkg::PINS_3);
			cfg_lanes <= qfr_lanes(write_mode_in, lane_mode_in,
				pin_config_in); // R2
			cfg_dly <= select_to_clock_delay_field_in; // R8
			cfg_len <= start_len; // R4
			cfg_cnt <= word_cnt_m1_in; // R5
			half_cyc <= start_half;
		end
	end

	// divider and half-period counting
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			hcnt <= '0;
			hh <= 4'h0;
		end
		else
		begin
			hcnt <= (is_idle || tick) ? '0 : hcnt + 1'b1; // R15
			if (start_ok || frame_end)
				hh <= 4'h0;
			else if (tick && state == qfr_pkg::qfr_st_trail)
				hh <= hh + 4'h1;
			else if (tick && state == qfr_pkg::qfr_st_lead &&
				hh != lead_last)
				hh <= hh + qfr_pkg::LEAD_BASE_HALVES;
		end
	end

	// serial clock and select; select held low across every word
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sclk <= qfr_pkg::SCLK_RESET;
			cs_n <= qfr_pkg::CS_N_RESET;
		end
		else
		begin
			if (rise_evt)
				sclk <= 1'b1; // R9
			else if (fall_evt)
				sclk <= 1'b0; // R9
			if (start_ok)
				cs_n <= 1'b0; // R13
			else if (trail_done)
				cs_n <= 1'b1; // R14
		end
	end

	// bit and word progress
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			bit_cnt <= '0;
			word_cnt <= '0;
		end
		else if (start_ok)
		begin
			bit_cnt <= '0;
			word_cnt <= '0;
		end
		else if (fall_evt)
		begin
			bit_cnt <= word_end ? '0 : bits_next; // R4
			if (word_end)
				word_cnt <= word_cnt + 1'b1; // R5
		end
	end

	// outgoing shifter moves at the same edge the clock falls
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			tx_sh <= '0;
			tx_take <= 1'b0;
		end
		else
		begin
			tx_take <= start_ok || (word_end && !frame_end);
			if (start_ok || (word_end && !frame_end))
				tx_sh <= tx_aligned;
			else if (fall_evt)
				tx_sh <= {tx_sh[MW-2:0], 1'b0}; // R12
		end
	end

	// pin synchroniser; the second stage holds the pin as seen at the fall
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			qio_meta <= qfr_pkg::QIO_SYNC_RESET;
			qio_sync <= qfr_pkg::QIO_SYNC_RESET;
		end
		else
		begin
			qio_meta <= qio_in;
			qio_sync <= qio_meta;
		end
	end

	// capture two cycles after each fall, matching the synchroniser delay
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cap_d1 <= 1'b0;
			cap_d2 <= 1'b0;
			last_d1 <= 1'b0;
			last_d2 <= 1'b0;
		end
		else
		begin
			cap_d1 <= fall_evt && !cfg_write; // R10
			cap_d2 <= cap_d1;
			last_d1 <= word_end && !cfg_write;
			last_d2 <= last_d1;
		end
	end

	// receive shifter relies on data held stable around each fall
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rx_sh <= '0;
		else if (cap_d2)
			rx_sh <= rx_next; // R10 R11
	end

	// finished word waits here until the buffer takes it
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			hold <= '0;
			hold_valid <= 1'b0;
		end
		else
		begin
			if (hold_load)
				hold <= rx_next & len_mask; // R3
			// a new word wins over the buffer taking the old one
			hold_valid <= hold_load || (hold_valid && !push_if.ready);
		end
	end

	// completion pulses, each behind its own enable
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			word_irq <= 1'b0;
			frame_irq <= 1'b0;
		end
		else
		begin
			word_irq <= word_irq_en_in &&
				(hold_load || (word_end && cfg_write)); // R7
			frame_irq <= frame_irq_en_in && trail_done; // R7
		end
	end

	assign push_if.valid = hold_valid;
	assign push_if.data = hold;
	assign pop_if.ready = rd_ready_in;

	qfr_fifo #(
		.WIDTH(MW),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.wr(push_if),
		.rd(pop_if)
	);

	// pins: controller only, so clock and select are always driven
	assign sclk_out = sclk; // R1
	assign cs_n_out = cs_n; // R1
	assign qio_out = {3'h0, tx_sh[MW-1]}; // R12
	assign qio_oe_n_out = {3'h7, !(drv0 && !cs_n)}; // R6
	assign busy_out = !is_idle;
	assign word_irq_out = word_irq;
	assign frame_irq_out = frame_irq;
	assign tx_take_out = tx_take;
	assign rd_valid_out = pop_if.valid;
	assign rd_data_out = pop_if.data;

endmodule // qfr_ctrl

// file: verilog/qfr_fifo.sv
// read word buffer: flip-flop storage with valid/ready on both sides
// assumes one clock; the drain side may hold ready low for any time
`timescale 1ns/1ps
module qfr_fifo #(
	parameter int WIDTH = 128,
	parameter int DEPTH = 16
)(
	input wire logic clk_in,
	input wire logic rstn_in,
	qfr_stream_if.snk wr,
	qfr_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	// pointer wrap logic needs a power of two of at least two
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("qfr_fifo depth must be a power of two");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr;
	logic [AW:0] rptr;

	// extra pointer bit tells full from empty
	wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
	wire empty = (wptr == rptr);
	wire do_wr = wr.valid && !full;
	wire do_rd = rd.ready && !empty;

	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem[rptr[AW-1:0]];

	// pointers
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wptr <= '0;
			rptr <= '0;
		end
		else
		begin
			if (do_wr)
				wptr <= wptr + 1'b1;
			if (do_rd)
				rptr <= rptr + 1'b1;
		end
	end

	// storage carries no reset; empty hides stale words
	always_ff @(posedge clk_in)
	begin
		if (do_wr)
			mem[wptr[AW-1:0]] <= wr.data;
	end

endmodule // qfr_fifo

// file: verilog/qfr_pkg.sv
// constants, encodings and state type of the quad serial flash read block
// assumes a single 100 MHz functional clock feeding every file of the block
package qfr_pkg;

	// functional clock and serial clock limits
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_MIN_PERIOD_NS = 25;
	// least half period in functional cycles, rounded up
	localparam int MIN_HALF_CYC =
		(SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

	// select low to first serial clock rise: two halves per delay step plus one
	localparam logic [3:0] LEAD_BASE_HALVES = 4'h1;
	// last falling edge to select release: two periods, four halves
	localparam logic [3:0] TRAIL_HALVES = 4'h4;

	// lane selection per access
	localparam logic [1:0] LANE_SINGLE = 2'h0;
	localparam logic [1:0] LANE_DUAL = 2'h1;
	localparam logic [1:0] LANE_QUAD = 2'h2;

	// external pin configuration
	localparam logic [1:0] PINS_3 = 2'h0;
	localparam logic [1:0] PINS_4 = 2'h1;
	localparam logic [1:0] PINS_6 = 2'h2;

	// values after reset
	localparam logic CS_N_RESET = 1'b1;
	localparam logic SCLK_RESET = 1'b0;
	localparam logic [3:0] QIO_SYNC_RESET = 4'h0;

	// frame sequencer states, one-hot
	typedef enum logic [3:0] {
		qfr_st_idle = 4'h1,
		qfr_st_lead = 4'h2,
		qfr_st_run = 4'h4,
		qfr_st_trail = 4'h8
	} qfr_state_t;

endpackage

// file: verilog/qfr_stream_if.sv
// valid/ready word stream between the sequencer and its read buffer
// assumes both ends sit on the same functional clock
`timescale 1ns/1ps
interface qfr_stream_if #(
	parameter int WIDTH = 128
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;

	// producer end
	modport src (
		output valid,
		output data,
		input ready
	);

	// consumer end
	modport snk (
		input valid,
		input data,
		output ready
	);
endinterface
